// file: rtl/open_drain_pkg.sv
// constants and types for the open-drain output pwm controller
package open_drain_pkg;

   // bus geometry
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 6;
   localparam int unsigned BE_W = 4;
   localparam int unsigned NUM_OUT = 2;

   // field widths
   localparam int unsigned MODE_W = 2;
   localparam int unsigned VOLT_W = 16;
   localparam int unsigned TIME_W = 16;
   localparam int unsigned CUR_W = 16;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned FREQ_W = 5;

   // output mode codes
   localparam logic [MODE_W-1:0] MODE_CONTACTOR = 2'h1;
   localparam logic [MODE_W-1:0] MODE_GENERAL = 2'h2;
   localparam logic [MODE_W-1:0] MODE_RESET = MODE_GENERAL;

   // bit positions in the drive status word and the command word
   localparam int unsigned STATUS_ON_BIT = 1;
   localparam int unsigned CMD_OUT_BIT0 = 6;

   // register byte offsets; each output owns a block of CH_STRIDE bytes
   localparam logic [ADDR_W-1:0] CH_STRIDE = 6'h10;
   localparam logic [ADDR_W-1:0] OFS_MODE = 6'h00;
   localparam logic [ADDR_W-1:0] OFS_PULL_T = 6'h04;
   localparam logic [ADDR_W-1:0] OFS_PULL_V = 6'h08;
   localparam logic [ADDR_W-1:0] OFS_HOLD_V = 6'h0c;
   localparam logic [ADDR_W-1:0] OFS_CURRENT = 6'h20;
   localparam logic [ADDR_W-1:0] OFS_FREQ = 6'h24;
   localparam logic [ADDR_W-1:0] OFS_CMD = 6'h28;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h2c;

   // reset values
   localparam logic [TIME_W-1:0] PULL_T_RESET = 16'h0000;
   localparam logic [VOLT_W-1:0] VOLT_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] CMD_RESET = 16'h0000;
   localparam logic [FREQ_W-1:0] FREQ_RESET = 5'h01;

   // carrier frequency settings in kHz
   localparam logic [FREQ_W-1:0] FREQ_1K = 5'h01;
   localparam logic [FREQ_W-1:0] FREQ_2K = 5'h02;
   localparam logic [FREQ_W-1:0] FREQ_4K = 5'h04;
   localparam logic [FREQ_W-1:0] FREQ_8K = 5'h08;
   localparam logic [FREQ_W-1:0] FREQ_16K = 5'h10;

   // timing
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned CARRIER_BASE_HZ = 1000;
   localparam int unsigned TICK_HZ = 500;
   localparam int unsigned MS_PER_S = 1000;
   localparam logic [TIME_W:0] TICK_MS = 17'h00002;

   // sequencing phase of one output
   typedef enum logic [2:0] {
      PH_OFF = 3'b001,
      PH_PULL = 3'b010,
      PH_HOLD = 3'b100
   } phase_t;

   // settings of one output
   typedef struct packed {
      logic [MODE_W-1:0] mode;
      logic [TIME_W-1:0] pull_ms;
      logic [VOLT_W-1:0] pull_cv;
      logic [VOLT_W-1:0] hold_cv;
   } out_cfg_t;

endpackage

// file: rtl/open_drain_pwm.sv
// open-drain output pwm controller with pull/hold sequencing and avalon-mm registers
// Summary of operation
// - two outputs, mode 1 contactor, 2 general
// - contactor mode follows switched-on status bit 1
// - general mode: command bits 6 and 7
// - output voltage realised by pwm duty
// - carrier 1 kHz at reset, 1..16 kHz
// - pull voltage for pull time, then hold
// - phases stepped on a 500 Hz tick
// - zero pull time skips the pull phase
// - pull time in ms, voltages in hundredth_volt_unit
// - total output current readable in mA
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
module open_drain_pwm #(
   parameter int unsigned TICK_CYCLES = open_drain_pkg::CLK_HZ / open_drain_pkg::TICK_HZ,
   parameter int unsigned BASE_PERIOD = open_drain_pkg::CLK_HZ / open_drain_pkg::CARRIER_BASE_HZ
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [open_drain_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [open_drain_pkg::BE_W-1:0] avs_byteenable_i,
   input wire logic [open_drain_pkg::DATA_W-1:0] avs_writedata_i,
   output logic [open_drain_pkg::DATA_W-1:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [open_drain_pkg::WORD_W-1:0] status_word_i,
   input wire logic [open_drain_pkg::VOLT_W-1:0] bus_voltage_i,
   input wire logic [open_drain_pkg::CUR_W-1:0] current_ma_i,
   input wire logic [open_drain_pkg::NUM_OUT-1:0] control_connector_i,
   output logic [open_drain_pkg::NUM_OUT-1:0] control_connector_o,
   output logic [open_drain_pkg::NUM_OUT-1:0] control_connector_oe_n_o
);
   import open_drain_pkg::*;

   localparam int unsigned CNT_W = $clog2(BASE_PERIOD + 1);
   localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);
   localparam int unsigned PROD_W = CNT_W + VOLT_W;
   localparam logic [CNT_W-1:0] BASE_PERIOD_C = CNT_W'(BASE_PERIOD);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

   // byte address of a per-output register
   function automatic logic [ADDR_W-1:0] ch_ofs(input int unsigned ch, input logic [ADDR_W-1:0] ofs);
      ch_ofs = ADDR_W'(ch * CH_STRIDE) + ofs;
   endfunction

   // merge write data into an old value under the byte enables
   function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_v,
                                                     input logic [DATA_W-1:0] new_v,
                                                     input logic [BE_W-1:0] be);
      lane_merge = old_v;
      for (int b = 0; b < BE_W; b++) begin
         if (be[b]) begin
            lane_merge[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
   endfunction

   // carrier period divider shift for a frequency setting; unknown codes run at 1 kHz
   function automatic logic [2:0] freq_shift(input logic [FREQ_W-1:0] f);
      case (f)
         FREQ_2K: freq_shift = 3'h1;
         FREQ_4K: freq_shift = 3'h2;
         FREQ_8K: freq_shift = 3'h3;
         FREQ_16K: freq_shift = 3'h4;
         default: freq_shift = 3'h0;
      endcase
   endfunction

   out_cfg_t cfg_r [NUM_OUT];
   logic [FREQ_W-1:0] freq_r;
   logic [WORD_W-1:0] cmd_r;
   logic ack_r;
   logic req;
   logic wr_take;
   logic [ADDR_W-1:0] word_addr;
   logic [DATA_W-1:0] rd_nxt;
   logic [DATA_W-1:0] wr_old;
   logic [DATA_W-1:0] wr_val;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] period_r;
   logic [CNT_W-1:0] period_nxt;
   logic [TICK_W-1:0] tick_cnt_r;
   logic tick_r;
   logic [NUM_OUT-1:0] pin_meta_r;
   logic [NUM_OUT-1:0] pin_sync_r;
   logic [NUM_OUT-1:0] en_w;
   logic [NUM_OUT-1:0] pull_w;
   logic [NUM_OUT-1:0] hold_w;
   logic [NUM_OUT-1:0] drive_w;

   // one wait cycle per access, then the answer
   assign req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = req & ~ack_r;
   assign wr_take = avs_write_i & ack_r;
   assign word_addr = {avs_address_i[ADDR_W-1:2], 2'b00};

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // old value of the addressed register, for byte-lane merging
   always_comb begin
      wr_old = '0;
      for (int i = 0; i < NUM_OUT; i++) begin
         if (word_addr == ch_ofs(i, OFS_MODE)) begin
            wr_old = DATA_W'(cfg_r[i].mode);
         end
         if (word_addr == ch_ofs(i, OFS_PULL_T)) begin
            wr_old = DATA_W'(cfg_r[i].pull_ms);
         end
         if (word_addr == ch_ofs(i, OFS_PULL_V)) begin
            wr_old = DATA_W'(cfg_r[i].pull_cv);
         end
         if (word_addr == ch_ofs(i, OFS_HOLD_V)) begin
            wr_old = DATA_W'(cfg_r[i].hold_cv);
         end
      end
      if (word_addr == OFS_FREQ) begin
         wr_old = DATA_W'(freq_r);
      end
      if (word_addr == OFS_CMD) begin
         wr_old = DATA_W'(cmd_r);
      end
   end

   assign wr_val = lane_merge(wr_old, avs_writedata_i, avs_byteenable_i);

   // per-output settings; mode, pull time in ms, voltages in hundredth_volt_unit
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_OUT; i++) begin
            cfg_r[i].mode <= MODE_RESET;
            cfg_r[i].pull_ms <= PULL_T_RESET;
            cfg_r[i].pull_cv <= VOLT_RESET;
            cfg_r[i].hold_cv <= VOLT_RESET;
         end
      end else if (wr_take) begin
         for (int i = 0; i < NUM_OUT; i++) begin
            if (word_addr == ch_ofs(i, OFS_MODE)) begin
               cfg_r[i].mode <= wr_val[MODE_W-1:0];
            end
            if (word_addr == ch_ofs(i, OFS_PULL_T)) begin
               cfg_r[i].pull_ms <= wr_val[TIME_W-1:0];
            end
            if (word_addr == ch_ofs(i, OFS_PULL_V)) begin
               cfg_r[i].pull_cv <= wr_val[VOLT_W-1:0];
            end
            if (word_addr == ch_ofs(i, OFS_HOLD_V)) begin
               cfg_r[i].hold_cv <= wr_val[VOLT_W-1:0];
            end
         end
      end
   end

   // shared carrier frequency setting
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         freq_r <= FREQ_RESET;
      end else if (wr_take && word_addr == OFS_FREQ) begin
         freq_r <= wr_val[FREQ_W-1:0];
      end
   end

   // command word copy; bits 6 and 7 switch the outputs in general mode
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         cmd_r <= CMD_RESET;
      end else if (wr_take && word_addr == OFS_CMD) begin
         cmd_r <= wr_val[WORD_W-1:0];
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rd_nxt = '0;
      for (int i = 0; i < NUM_OUT; i++) begin
         if (word_addr == ch_ofs(i, OFS_MODE)) begin
            rd_nxt = DATA_W'(cfg_r[i].mode);
         end
         if (word_addr == ch_ofs(i, OFS_PULL_T)) begin
            rd_nxt = DATA_W'(cfg_r[i].pull_ms);
         end
         if (word_addr == ch_ofs(i, OFS_PULL_V)) begin
            rd_nxt = DATA_W'(cfg_r[i].pull_cv);
         end
         if (word_addr == ch_ofs(i, OFS_HOLD_V)) begin
            rd_nxt = DATA_W'(cfg_r[i].hold_cv);
         end
      end
      if (word_addr == OFS_CURRENT) begin
         rd_nxt = DATA_W'(current_ma_i);
      end
      if (word_addr == OFS_FREQ) begin
         rd_nxt = DATA_W'(freq_r);
      end
      if (word_addr == OFS_CMD) begin
         rd_nxt = DATA_W'(cmd_r);
      end
      if (word_addr == OFS_STATUS) begin
         rd_nxt = DATA_W'({pin_sync_r, drive_w, hold_w, pull_w, en_w});
      end
   end

   // read data captured in the wait cycle, stands while the answer is given
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= '0;
      end else if (avs_read_i && !ack_r) begin
         avs_readdata_o <= rd_nxt;
      end
   end

   // carrier counter; a new frequency takes effect at the end of a period
   assign period_nxt = BASE_PERIOD_C >> freq_shift(freq_r);

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         cnt_r <= '0;
         period_r <= BASE_PERIOD_C;
      end else if (cnt_r >= period_r - 1'b1) begin
         cnt_r <= '0;
         period_r <= period_nxt;
      end else begin
         cnt_r <= cnt_r + 1'b1;
      end
   end

   // 500 Hz sequencing tick
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         tick_cnt_r <= '0;
         tick_r <= 1'b0;
      end else if (tick_cnt_r == TICK_LAST) begin
         tick_cnt_r <= '0;
         tick_r <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
         tick_r <= 1'b0;
      end
   end

   // pin level read back through two flip-flops
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
      end else begin
         pin_meta_r <= control_connector_i;
         pin_sync_r <= pin_meta_r;
      end
   end

   // one sequencer and modulator per output
   for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
      phase_t phase_r;
      logic [TIME_W:0] elapsed_r;
      logic drive_r;
      logic en;
      logic [VOLT_W-1:0] volt;
      logic [PROD_W-1:0] lhs;
      logic [PROD_W-1:0] rhs;

      // enable source selected by the output's mode
      always_comb begin
         unique case (cfg_r[g].mode)
            MODE_CONTACTOR: en = status_word_i[STATUS_ON_BIT];
            MODE_GENERAL: en = cmd_r[CMD_OUT_BIT0 + g];
            default: en = 1'b0;
         endcase
      end

      // pull then hold, stepped on the tick; zero pull time goes straight to hold
      always_ff @(posedge clock_i) begin
         if (!rst_n_i) begin
            phase_r <= PH_OFF;
            elapsed_r <= '0;
         end else if (tick_r) begin
            unique case (phase_r)
               PH_OFF: begin
                  elapsed_r <= '0;
                  if (en) begin
                     phase_r <= (cfg_r[g].pull_ms == '0) ? PH_HOLD : PH_PULL;
                  end
               end
               PH_PULL: begin
                  if (!en) begin
                     phase_r <= PH_OFF;
                  end else if (elapsed_r + TICK_MS >= {1'b0, cfg_r[g].pull_ms}) begin
                     phase_r <= PH_HOLD;
                  end else begin
                     elapsed_r <= elapsed_r + TICK_MS;
                  end
               end
               PH_HOLD: begin
                  if (!en) begin
                     phase_r <= PH_OFF;
                  end
               end
               default: begin
                  phase_r <= PH_OFF;
               end
            endcase
         end
      end

      // commanded voltage of the current phase
      always_comb begin
         unique case (phase_r)
            PH_PULL: volt = cfg_r[g].pull_cv;
            PH_HOLD: volt = cfg_r[g].hold_cv;
            default: volt = '0;
         endcase
      end

      // switch on while cnt/period < volt/bus; volt above bus gives full on
      assign lhs = PROD_W'(cnt_r) * PROD_W'(bus_voltage_i);
      assign rhs = PROD_W'(volt) * PROD_W'(period_r);

      always_ff @(posedge clock_i) begin
         if (!rst_n_i) begin
            drive_r <= 1'b0;
         end else begin
            drive_r <= en && (phase_r != PH_OFF) && (lhs < rhs);
         end
      end

      assign en_w[g] = en;
      assign pull_w[g] = (phase_r == PH_PULL);
      assign hold_w[g] = (phase_r == PH_HOLD);
      assign drive_w[g] = drive_r;
   end

   // open drain: pull low when the switch is on, release otherwise
   assign control_connector_o = '0;
   assign control_connector_oe_n_o = ~drive_w;

endmodule

// file: test/open_drain_pwm_chk.sv
// concurrent checks on the open-drain pwm controller ports
`timescale 1ns/1ns
module open_drain_pwm_chk #(
   parameter int unsigned TICK_CYCLES = 20,
   parameter int unsigned BASE_PERIOD = 160
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [15:0] status_word_i,
   input wire logic [15:0] bus_voltage_i,
   input wire logic [15:0] current_ma_i,
   input wire logic [1:0] control_connector_i,
   input wire logic [1:0] control_connector_o,
   input wire logic [1:0] control_connector_oe_n_o
);
   import open_drain_pkg::*;
   logic [1:0] mode_r [2];
   logic [15:0] pull_t_r [2];
   logic [15:0] hold_v_r [2];
   logic [15:0] cmd_r;
   logic [1:0] en;
   int unsigned on_r [2];
   wire [1:0] rel = control_connector_oe_n_o;
   wire wr = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
   wire [5:0] a = avs_address_i;
   // shadow of the settings taken over the bus
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         mode_r <= '{MODE_RESET, MODE_RESET};
         pull_t_r <= '{PULL_T_RESET, PULL_T_RESET};
         hold_v_r <= '{VOLT_RESET, VOLT_RESET};
         cmd_r <= CMD_RESET;
      end else if (wr && !a[5]) begin
         case (a[3:2])
            2'h0: mode_r[a[4]] <= avs_writedata_i[1:0];
            2'h1: pull_t_r[a[4]] <= avs_writedata_i[15:0];
            2'h3: hold_v_r[a[4]] <= avs_writedata_i[15:0];
            default: ;
         endcase
      end else if (wr && a == OFS_CMD) begin
         cmd_r <= avs_writedata_i[15:0];
      end
   end
   // enable source of each output
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         en[k] = (mode_r[k] == MODE_CONTACTOR && status_word_i[STATUS_ON_BIT])
            || (mode_r[k] == MODE_GENERAL && cmd_r[CMD_OUT_BIT0 + k]);
      end
   end
   // cycles each output has stayed enabled
   always_ff @(posedge clock_i) begin
      for (int k = 0; k < 2; k++) begin
         if (!rst_n_i || !en[k]) begin
            on_r[k] <= 0;
         end else if (on_r[k] < 1000) begin
            on_r[k] <= on_r[k] + 1;
         end
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   wait_one_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus answer not after one wait cycle");
   out1_enable_a: assert property ($fell(rel[0]) |-> $past(en[0]))
      else $error("output 1 switched on while disabled");
   out2_enable_a: assert property ($fell(rel[1]) |-> $past(en[1]))
      else $error("output 2 switched on while disabled");
   out1_off_a: assert property (!en[0] [*3] |-> rel[0])
      else $error("output 1 conducts while disabled");
   out2_off_a: assert property (!en[1] [*3] |-> rel[1])
      else $error("output 2 conducts while disabled");
   hold_full_a: assert property (en[0] && on_r[0] > TICK_CYCLES + 3 && pull_t_r[0] == 0
      && hold_v_r[0] > bus_voltage_i |-> !rel[0]) else $error("hold above bus not fully on");
   drive_low_a: assert property (control_connector_o == 2'h0)
      else $error("open-drain data not low");
   reset_off_a: assert property ($rose(rst_n_i) |-> rel == 2'h3)
      else $error("outputs not released after reset");
   current_rd_a: assert property (avs_read_i && !avs_waitrequest_o && a == OFS_CURRENT
      |-> avs_readdata_o == {16'h0000, $past(current_ma_i)}) else $error("current read wrong");
endmodule
bind open_drain_pwm open_drain_pwm_chk #(.TICK_CYCLES(TICK_CYCLES), .BASE_PERIOD(BASE_PERIOD)) chk (
   .clock_i(clock_i),
   .rst_n_i(rst_n_i),
   .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i),
   .avs_byteenable_i(avs_byteenable_i),
   .avs_writedata_i(avs_writedata_i),
   .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o),
   .status_word_i(status_word_i),
   .bus_voltage_i(bus_voltage_i),
   .current_ma_i(current_ma_i),
   .control_connector_i(control_connector_i),
   .control_connector_o(control_connector_o),
   .control_connector_oe_n_o(control_connector_oe_n_o)
);

// file: test/coil_load_model.sv
// inductive coil load on both open-drain outputs
`timescale 1ns/1ns
module coil_load_model #(
   parameter logic [15:0] RAMP_MA = 16'h0003
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [1:0] drive_i,
   input wire logic [1:0] oe_n_i,
   output logic [1:0] pin_o,
   output logic [15:0] current_ma_o
);
   // a released pin is pulled up through the coil, a conducting switch drives it
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         pin_o[k] = oe_n_i[k] ? 1'b1 : drive_i[k];
      end
   end
   // coil current builds while a switch conducts and stays flat once released
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         current_ma_o <= 16'h0000;
      end else if (oe_n_i != 2'h3 && current_ma_o < 16'h7000) begin
         current_ma_o <= current_ma_o + RAMP_MA;
      end
   end
endmodule

// file: test/open_drain_pwm_test.sv
// self-checking bench for the open-drain output pwm controller
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected at %0t got %h expected %h", $time, (g), (e)); end end
module open_drain_pwm_test;
   import open_drain_pkg::*;
   typedef struct {int lo; int hi; int off;} note_t;
   localparam int TICK = 20;
   localparam int BASE = 160;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [5:0] avs_address_i = 6'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [3:0] avs_byteenable_i = 4'hf;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [15:0] status_word_i = 16'h0000;
   logic [15:0] bus_voltage_i = 16'h12c0;
   logic [15:0] current_ma_i;
   logic [1:0] control_connector_i;
   logic [1:0] control_connector_o;
   logic [1:0] control_connector_oe_n_o;
   logic [31:0] rd_q [$];
   note_t run_q [$];
   note_t nt;
   logic [31:0] seed = 32'h27;
   logic [31:0] exp_d;
   logic [31:0] got_d;
   logic mon_ch = 1'b0;
   logic prev = 1'b1;
   logic lvl;
   logic hi_armed = 1'b0;
   int run_len = 0;
   int err_total = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [4:0] freqs [5] = '{FREQ_1K, FREQ_2K, FREQ_4K, FREQ_8K, FREQ_16K};
   int pulls [3] = '{0, 1, 4};
   open_drain_pwm #(.TICK_CYCLES(TICK), .BASE_PERIOD(BASE)) dut (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i),
      .avs_byteenable_i(avs_byteenable_i),
      .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .status_word_i(status_word_i),
      .bus_voltage_i(bus_voltage_i),
      .current_ma_i(current_ma_i),
      .control_connector_i(control_connector_i),
      .control_connector_o(control_connector_o),
      .control_connector_oe_n_o(control_connector_oe_n_o)
   );
   coil_load_model load (.clock_i(clock_i), .rst_n_i(rst_n_i), .drive_i(control_connector_o),
      .oe_n_i(control_connector_oe_n_o), .pin_o(control_connector_i), .current_ma_o(current_ma_i));
   // xorshift source of random stimulus
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // one avalon transfer held until waitrequest is seen low
   task bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
      int n;
      n = 0;
      avs_address_i <= ad;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      @(posedge clock_i);
      while (avs_waitrequest_o !== 1'b0 && n < 100) begin
         @(posedge clock_i);
         n++;
      end
      if (n >= 100) err_total++;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clock_i);
   endtask
   task wr(input logic [5:0] ad, input logic [31:0] d);
      bus(1'b1, ad, d);
   endtask
   task rd(input logic [5:0] ad, input logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, ad, 32'h0);
   endtask
   task wait_runs();
      int n;
      n = 0;
      while (run_q.size() != 0 && n < 3000) begin
         @(posedge clock_i);
         n++;
      end
      if (n >= 3000) err_total++;
   endtask
   initial begin
      forever #5 clock_i = ~clock_i;
   end
   // read answers and switch-on/off run lengths against the oldest note
   always @(posedge clock_i) begin
      if (avs_read_i && avs_waitrequest_o === 1'b0) begin
         got_d = rd_q.pop_front();
         `CHK(avs_readdata_o, got_d)
      end
      lvl = control_connector_oe_n_o[mon_ch];
      if (lvl !== prev && run_q.size() != 0) begin
         nt = run_q[0];
         if (prev === 1'b0 && !hi_armed) begin
            `CHK(run_len >= nt.lo && run_len <= nt.hi, 1'b1)
            hi_armed = (nt.off != 0);
            if (!hi_armed) void'(run_q.pop_front());
         end else if (prev === 1'b1 && hi_armed) begin
            `CHK(run_len, nt.off)
            hi_armed = 1'b0;
            void'(run_q.pop_front());
         end
      end
      run_len = (lvl !== prev) ? 1 : run_len + 1;
      prev = lvl;
   end
   // hang guard
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         end_of_test();
      end
   end
   initial begin
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1'b1;
      @(posedge clock_i);
      // reset values, an unmapped place and the read-only current
      rd(OFS_MODE, {30'h0, MODE_RESET});
      rd(CH_STRIDE, {30'h0, MODE_RESET});
      rd(OFS_FREQ, {27'h0, FREQ_RESET});
      rd(OFS_CMD, 32'h0);
      rd(6'h30, 32'h0);
      exp_d = xs() & 32'hffff;
      wr(OFS_PULL_V, exp_d);
      rd(OFS_PULL_V, exp_d);
      wr(OFS_CURRENT, 32'hffff);
      rd(OFS_CURRENT, {16'h0, current_ma_i});
      // half duty at every carrier setting on a random bus voltage
      exp_d = xs();
      bus_voltage_i <= {3'h0, exp_d[12:1], 1'b0} + 16'h0200;
      @(posedge clock_i);
      wr(OFS_HOLD_V, {17'h0, bus_voltage_i[15:1]});
      wr(OFS_CMD, 32'h40);
      foreach (freqs[i]) begin
         wr(OFS_FREQ, {27'h0, freqs[i]});
         repeat (400) @(posedge clock_i);
         while (control_connector_oe_n_o[0] !== 1'b1) @(posedge clock_i);
         run_q.push_back('{BASE / freqs[i] / 2, BASE / freqs[i] / 2, BASE / freqs[i] / 2});
         wait_runs();
      end
      // full pull voltage for whole ticks after each fresh enable
      wr(OFS_PULL_V, 32'hffff);
      foreach (pulls[i]) begin
         wr(OFS_CMD, 32'h0);
         repeat (2 * TICK) @(posedge clock_i);
         wr(OFS_PULL_T, pulls[i]);
         run_q.push_back('{(pulls[i] + 1) / 2 * TICK, (pulls[i] + 1) / 2 * TICK + 5, 0});
         wr(OFS_CMD, 32'h40);
         wait_runs();
      end
      // contactor mode follows the switched-on flag
      wr(OFS_CMD, 32'h0);
      wr(OFS_PULL_T, 32'h0);
      wr(OFS_MODE, 32'h1);
      run_q.push_back('{0, 5, 5});
      status_word_i <= 16'h0002;
      wait_runs();
      status_word_i <= 16'h0000;
      // second output on its own command bit
      wr(OFS_MODE, 32'h2);
      wr(CH_STRIDE + OFS_HOLD_V, {17'h0, bus_voltage_i[15:1]});
      mon_ch <= 1'b1;
      run_q.push_back('{0, 5, 5});
      wr(OFS_CMD, 32'h80);
      wait_runs();
      // hold above the bus gives the full bus voltage
      wr(OFS_CMD, 32'h0);
      bus_voltage_i <= 16'h12c0;
      wr(OFS_HOLD_V, 32'h2710);
      wr(OFS_CMD, 32'h40);
      repeat (3 * TICK) @(posedge clock_i);
      repeat (20) begin
         @(posedge clock_i);
         `CHK(control_connector_oe_n_o[0], 1'b0)
      end
      wr(OFS_CMD, 32'h0);
      repeat (10) @(posedge clock_i);
      rd(OFS_CURRENT, {16'h0, current_ma_i});
      // an unused mode code keeps the output off; status shows released pins only
      wr(OFS_MODE, 32'h3);
      wr(OFS_CMD, 32'h40);
      repeat (2 * TICK) @(posedge clock_i);
      rd(OFS_STATUS, 32'h300);
      end_of_test();
   end
endmodule
